// ---- shared/cbt_cfg.svh ----
/*
  Constants of the bit, transfer and control execution block:
  status flag positions, reset values and cycle counts per group.
  Included by the execution stage (cbt_exec) only; definitions only.
*/
`ifndef CBT_CFG_SVH
`define CBT_CFG_SVH

// ----------------------------------------------------------------
// status flag bit positions
// ----------------------------------------------------------------
`define CBT_SF_C 3'h0
`define CBT_SF_Z 3'h1
`define CBT_SF_N 3'h2
`define CBT_SF_V 3'h3
`define CBT_SF_S 3'h4
`define CBT_SF_H 3'h5
`define CBT_SF_T 3'h6
`define CBT_SF_I 3'h7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CBT_FLAGS_RST 8'h00
`define CBT_PTR_RST   16'h0000
`define CBT_SP_RST    16'h00FF

// ----------------------------------------------------------------
// cycle counts per instruction group
// ----------------------------------------------------------------
`define CBT_CYC_ONE 2'h1
`define CBT_CYC_MEM 2'h2
`define CBT_CYC_PM  2'h3

`endif

// ---- shared/cbt_pkg.sv ----
/*
  Types of the bit, transfer and control execution block: decoded
  operations, pointer selects, phases and the request carriers.
  Assumes an upstream decoder turns opcodes into cbt_instr_t.
*/
`default_nettype none

package cbt_pkg;

  // ----------------------------------------------------------------
  // decoded operations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    nop_op                   = 5'b00000,
    sleep_op                 = 5'b00001,
    watchdog_restart_op      = 5'b00010,
    break_op                 = 5'b00011,
    io_bit_set_op            = 5'b00100,
    io_bit_clear_op          = 5'b00101,
    logical_left_shift_op    = 5'b00110,
    logical_right_shift_op   = 5'b00111,
    rotate_left_carry_op     = 5'b01000,
    rotate_right_carry_op    = 5'b01001,
    arith_right_shift_op     = 5'b01010,
    swap_nibble_op           = 5'b01011,
    flag_set_generic_op      = 5'b01100,
    flag_clear_generic_op    = 5'b01101,
    half_carry_set_op        = 5'b01110,
    overflow_clear_op        = 5'b01111,
    bit_to_transfer_flag_op  = 5'b10000,
    transfer_flag_to_bit_op  = 5'b10001,
    move_op                  = 5'b10010,
    load_imm_op              = 5'b10011,
    ptr_set_op               = 5'b10100,
    ptr_load_op              = 5'b10101,
    load_offset_op           = 5'b10110,
    ptr_store_op             = 5'b10111,
    store_offset_op          = 5'b11000,
    load_direct_op           = 5'b11001,
    store_direct_op          = 5'b11010,
    program_memory_read_op   = 5'b11011,
    io_in_op                 = 5'b11100,
    io_out_op                = 5'b11101,
    push_op                  = 5'b11110,
    pop_op                   = 5'b11111
  } cbt_op_t;

  typedef enum logic [1:0] {
    CBT_PX  = 2'b00,
    CBT_PY  = 2'b01,
    CBT_PZ  = 2'b10,
    CBT_PSP = 2'b11
  } cbt_ptr_t;

  typedef enum logic [1:0] {
    CBT_AM_PLAIN = 2'b00,
    CBT_AM_INC   = 2'b01,
    CBT_AM_DEC   = 2'b10
  } cbt_amode_t;

  typedef enum logic [1:0] {
    CBT_PH_IDLE = 2'b00,
    CBT_PH_1    = 2'b01,
    CBT_PH_2    = 2'b10,
    CBT_PH_3    = 2'b11
  } cbt_phase_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    cbt_op_t    op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bsel;
    logic [5:0] io_a;
    cbt_ptr_t   ptr;
    cbt_amode_t mode;
    logic [5:0] disp;
    logic [15:0] k;
  } cbt_instr_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        re;
    logic        we;
  } cbt_dm_req_t;

  typedef struct packed {
    logic [5:0] raddr;
    logic       re;
    logic [5:0] waddr;
    logic [7:0] wdata;
    logic       we;
  } cbt_io_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        re;
  } cbt_pm_req_t;

  typedef struct packed {
    logic [7:0]  flags;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic [15:0] sp;
  } cbt_state_t;

endpackage : cbt_pkg

`default_nettype wire

// ---- rtl/cbt_regfile.sv ----
/*
  Working register file: two registered read ports, one write port.
  A write to the address being read is forwarded into the read
  register, so back-to-back dependent instructions see new data.
*/
`timescale 1ns/100ps
`default_nettype none

module cbt_regfile #(
  parameter int unsigned NREG = 32,
  parameter int unsigned AW   = 5
) (
  // clock
  input  wire logic          clk,
  // read ports
  input  wire logic [AW-1:0] ra_a,
  input  wire logic [AW-1:0] ra_b,
  output var  logic [7:0]    rd_a,
  output var  logic [7:0]    rd_b,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] wa,
  input  wire logic [7:0]    wd
);

  logic [7:0] mem [NREG];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[wa] <= wd;
    end
  end

  // bypass keeps the read register coherent with a same-edge write
  always_ff @(posedge clk) begin
    rd_a <= (we && wa == ra_a) ? wd : mem[ra_a];
    rd_b <= (we && wa == ra_b) ? wd : mem[ra_b];
  end

endmodule : cbt_regfile

`default_nettype wire

// ---- rtl/cbt_exec.sv ----
/*
  Execution stage for the bit, data-transfer and control groups of
  an 8-bit core. Takes decoded instructions with valid/ready, drives
  data memory, I/O space and program memory, holds flags and pointers.
  Assumes all memories run on clk; data memory answers one cycle
  after its read strobe, I/O in the same cycle, program memory two.
*/
`timescale 1ns/100ps
`default_nettype none

`include "cbt_cfg.svh"

module cbt_exec (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // decoded instruction stream
  input  wire logic                in_valid,
  input  wire cbt_pkg::cbt_instr_t in_instr,
  output var  logic                in_ready,
  // data memory
  output var  cbt_pkg::cbt_dm_req_t dm_req,
  input  wire logic [7:0]          dm_rdata,
  // I/O space
  output var  cbt_pkg::cbt_io_req_t io_req,
  input  wire logic [7:0]          io_rdata,
  // program memory
  output var  cbt_pkg::cbt_pm_req_t pm_req,
  input  wire logic [7:0]          pm_rdata,
  // control pulses
  output var  logic                sleep_req,
  output var  logic                wdt_restart,
  output var  logic                brk_req,
  // core state
  output var  cbt_pkg::cbt_state_t core_state
);
  import cbt_pkg::*;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [1:0] op_cycles(input cbt_op_t op);
    case (op)
      io_bit_set_op, io_bit_clear_op, ptr_load_op, load_offset_op,
      ptr_store_op, store_offset_op, load_direct_op, store_direct_op,
      push_op, pop_op:        op_cycles = `CBT_CYC_MEM;
      program_memory_read_op: op_cycles = `CBT_CYC_PM;
      default:                op_cycles = `CBT_CYC_ONE;
    endcase
  endfunction : op_cycles

  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction : bit_mask

  function automatic logic is_load(input cbt_op_t op);
    is_load = (op == ptr_load_op) || (op == load_offset_op) ||
              (op == load_direct_op) || (op == pop_op);
  endfunction : is_load

  function automatic logic is_store(input cbt_op_t op);
    is_store = (op == ptr_store_op) || (op == store_offset_op) ||
               (op == store_direct_op) || (op == push_op);
  endfunction : is_store

  // returns {carry_out, result}
  function automatic logic [8:0] shift_res(input cbt_op_t op,
                                           input logic [7:0] a,
                                           input logic c);
    case (op)
      logical_left_shift_op:  shift_res = {a[7], a[6:0], 1'b0};
      logical_right_shift_op: shift_res = {a[0], 1'b0, a[7:1]};
      rotate_left_carry_op:   shift_res = {a[7], a[6:0], c};
      rotate_right_carry_op:  shift_res = {a[0], c, a[7:1]};
      default:                shift_res = {a[0], a[7], a[7:1]};
    endcase
  endfunction : shift_res

  function automatic logic is_shift(input cbt_op_t op);
    is_shift = (op == logical_left_shift_op) ||
               (op == logical_right_shift_op) ||
               (op == rotate_left_carry_op) ||
               (op == rotate_right_carry_op) ||
               (op == arith_right_shift_op);
  endfunction : is_shift

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cbt_phase_t  phase_r;
  cbt_phase_t  phase_nxt;
  cbt_instr_t  cur_r;
  logic [7:0]  flags_r;
  logic [15:0] x_r;
  logic [15:0] y_r;
  logic [15:0] z_r;
  logic [15:0] sp_r;
  logic [15:0] dm_addr_r;
  logic [7:0]  dm_wdata_r;
  logic        dm_re_r;
  logic        dm_we_r;
  logic [5:0]  io_raddr_r;
  logic        io_re_r;
  logic [5:0]  io_waddr_r;
  logic [7:0]  io_wdata_r;
  logic        io_we_r;
  logic [15:0] pm_addr_r;
  logic        pm_re_r;
  logic        sleep_r;
  logic        wdt_r;
  logic        brk_r;

  logic        last;
  logic        accept;
  logic        first;
  logic [7:0]  rda;
  logic [7:0]  rdb;
  logic        wb_en;
  logic [7:0]  wb_val;
  logic        ptr_we;
  cbt_ptr_t    ptr_sel;
  logic [15:0] ptr_val;
  logic [15:0] x_fw;
  logic [15:0] y_fw;
  logic [15:0] z_fw;
  logic [15:0] sp_fw;
  logic [15:0] in_ptr;
  logic [15:0] cur_ptr;
  logic [15:0] ea;
  logic [8:0]  sh;

  // ----------------------------------------------------------------
  // issue control
  // ----------------------------------------------------------------
  assign first = (phase_r == CBT_PH_1);
  assign last  = (phase_r != CBT_PH_IDLE) &&
                 (phase_r == cbt_phase_t'(op_cycles(cur_r.op)));
  assign in_ready = (phase_r == CBT_PH_IDLE) || last;
  assign accept   = in_valid && in_ready;

  always_comb begin
    if (accept) begin
      phase_nxt = CBT_PH_1;
    end else if (last) begin
      phase_nxt = CBT_PH_IDLE;
    end else begin
      case (phase_r)
        CBT_PH_1: phase_nxt = CBT_PH_2;
        CBT_PH_2: phase_nxt = CBT_PH_3;
        default:  phase_nxt = CBT_PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_r <= CBT_PH_IDLE;
      cur_r   <= '0;
    end else begin
      phase_r <= phase_nxt;
      if (accept) begin
        cur_r <= in_instr;
      end
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  cbt_regfile #(
    .NREG (32),
    .AW   (5)
  ) u_regs (
    .clk  (clk),
    .ra_a (accept ? in_instr.rd : cur_r.rd),
    .ra_b (accept ? in_instr.rr : cur_r.rr),
    .rd_a (rda),
    .rd_b (rdb),
    .we   (wb_en),
    .wa   (cur_r.rd),
    .wd   (wb_val)
  );

  assign sh = shift_res(cur_r.op, rda, flags_r[`CBT_SF_C]);

  always_comb begin
    wb_en  = last;
    wb_val = 8'h00;
    case (cur_r.op)
      logical_left_shift_op, logical_right_shift_op,
      rotate_left_carry_op, rotate_right_carry_op,
      arith_right_shift_op:    wb_val = sh[7:0];
      swap_nibble_op:          wb_val = {rda[3:0], rda[7:4]};
      transfer_flag_to_bit_op: wb_val = flags_r[`CBT_SF_T] ?
                                        (rda | bit_mask(cur_r.bsel)) :
                                        (rda & ~bit_mask(cur_r.bsel));
      move_op:                 wb_val = rdb;
      load_imm_op:             wb_val = cur_r.k[7:0];
      ptr_load_op, load_offset_op,
      load_direct_op, pop_op:  wb_val = dm_rdata;
      program_memory_read_op:  wb_val = pm_rdata;
      io_in_op:                wb_val = io_rdata;
      default:                 wb_en  = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // pointers
  // ----------------------------------------------------------------
  // pointer moves land at the end of the first cycle
  always_comb begin
    ptr_we  = 1'b0;
    ptr_sel = cur_r.ptr;
    ptr_val = cur_ptr;
    if (first) begin
      case (cur_r.op)
        ptr_set_op: begin
          ptr_we  = 1'b1;
          ptr_val = cur_r.k;
        end
        ptr_load_op, ptr_store_op: begin
          ptr_we  = (cur_r.mode != CBT_AM_PLAIN);
          ptr_val = (cur_r.mode == CBT_AM_DEC) ? cur_ptr - 16'h0001 :
                                                 cur_ptr + 16'h0001;
        end
        push_op: begin
          ptr_we  = 1'b1;
          ptr_sel = CBT_PSP;
          ptr_val = sp_r - 16'h0001;
        end
        pop_op: begin
          ptr_we  = 1'b1;
          ptr_sel = CBT_PSP;
          ptr_val = sp_r + 16'h0001;
        end
        program_memory_read_op: begin
          ptr_we  = (cur_r.mode == CBT_AM_INC);
          ptr_sel = CBT_PZ;
          ptr_val = z_r + 16'h0001;
        end
        default: ptr_we = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      x_r  <= `CBT_PTR_RST;
      y_r  <= `CBT_PTR_RST;
      z_r  <= `CBT_PTR_RST;
      sp_r <= `CBT_SP_RST;
    end else if (ptr_we) begin
      case (ptr_sel)
        CBT_PX:  x_r  <= ptr_val;
        CBT_PY:  y_r  <= ptr_val;
        CBT_PZ:  z_r  <= ptr_val;
        default: sp_r <= ptr_val;
      endcase
    end
  end

  // forwarded pointers let an access issue on the edge of an update
  assign x_fw  = (ptr_we && ptr_sel == CBT_PX)  ? ptr_val : x_r;
  assign y_fw  = (ptr_we && ptr_sel == CBT_PY)  ? ptr_val : y_r;
  assign z_fw  = (ptr_we && ptr_sel == CBT_PZ)  ? ptr_val : z_r;
  assign sp_fw = (ptr_we && ptr_sel == CBT_PSP) ? ptr_val : sp_r;

  always_comb begin
    case (cur_r.ptr)
      CBT_PX:  cur_ptr = x_r;
      CBT_PY:  cur_ptr = y_r;
      CBT_PZ:  cur_ptr = z_r;
      default: cur_ptr = sp_r;
    endcase
    case (in_instr.ptr)
      CBT_PX:  in_ptr = x_fw;
      CBT_PY:  in_ptr = y_fw;
      CBT_PZ:  in_ptr = z_fw;
      default: in_ptr = sp_fw;
    endcase
  end

  // effective data address of the instruction being taken
  always_comb begin
    case (in_instr.op)
      ptr_load_op, ptr_store_op:
        ea = (in_instr.mode == CBT_AM_DEC) ? in_ptr - 16'h0001 : in_ptr;
      load_offset_op, store_offset_op:
        ea = in_ptr + {10'h000, in_instr.disp};
      load_direct_op, store_direct_op:
        ea = in_instr.k;
      pop_op:  ea = sp_fw + 16'h0001;
      default: ea = sp_fw;
    endcase
  end

  // ----------------------------------------------------------------
  // data memory
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dm_addr_r  <= 16'h0000;
      dm_wdata_r <= 8'h00;
      dm_re_r    <= 1'b0;
      dm_we_r    <= 1'b0;
    end else begin
      if (accept && (is_load(in_instr.op) || is_store(in_instr.op))) begin
        dm_addr_r <= ea;
      end
      dm_re_r <= accept && is_load(in_instr.op);
      dm_we_r <= first && is_store(cur_r.op);
      if (first && is_store(cur_r.op)) begin
        dm_wdata_r <= rdb;
      end
    end
  end

  // ----------------------------------------------------------------
  // I/O space
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_raddr_r <= 6'h00;
      io_re_r    <= 1'b0;
      io_waddr_r <= 6'h00;
      io_wdata_r <= 8'h00;
      io_we_r    <= 1'b0;
    end else begin
      if (accept) begin
        io_raddr_r <= in_instr.io_a;
      end
      io_re_r <= accept && (in_instr.op == io_in_op ||
                            in_instr.op == io_bit_set_op ||
                            in_instr.op == io_bit_clear_op);
      io_we_r <= first && (cur_r.op == io_out_op ||
                           cur_r.op == io_bit_set_op ||
                           cur_r.op == io_bit_clear_op);
      if (first) begin
        io_waddr_r <= cur_r.io_a;
        case (cur_r.op)
          io_bit_set_op:   io_wdata_r <= io_rdata | bit_mask(cur_r.bsel);
          io_bit_clear_op: io_wdata_r <= io_rdata & ~bit_mask(cur_r.bsel);
          default:         io_wdata_r <= rdb;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // program memory and control pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pm_addr_r <= 16'h0000;
      pm_re_r   <= 1'b0;
    end else begin
      if (accept && in_instr.op == program_memory_read_op) begin
        pm_addr_r <= z_fw;
      end
      pm_re_r <= accept && in_instr.op == program_memory_read_op;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sleep_r <= 1'b0;
      wdt_r   <= 1'b0;
      brk_r   <= 1'b0;
    end else begin
      sleep_r <= accept && in_instr.op == sleep_op;
      wdt_r   <= accept && in_instr.op == watchdog_restart_op;
      brk_r   <= accept && in_instr.op == break_op;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // every flag instruction is single cycle, so first is also last
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_r <= `CBT_FLAGS_RST;
    end else if (first) begin
      if (is_shift(cur_r.op)) begin
        flags_r[`CBT_SF_C] <= sh[8];
        flags_r[`CBT_SF_Z] <= (sh[7:0] == 8'h00);
        flags_r[`CBT_SF_N] <= sh[7];
        flags_r[`CBT_SF_V] <= sh[7] ^ sh[8];
      end else begin
        case (cur_r.op)
          flag_set_generic_op:     flags_r[cur_r.bsel]    <= 1'b1;
          flag_clear_generic_op:   flags_r[cur_r.bsel]    <= 1'b0;
          overflow_clear_op:       flags_r[`CBT_SF_V]     <= 1'b0;
          half_carry_set_op:       flags_r[`CBT_SF_H]     <= 1'b1;
          bit_to_transfer_flag_op: flags_r[`CBT_SF_T]     <= rdb[cur_r.bsel];
          default:                 flags_r                <= flags_r;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    dm_req.addr  = dm_addr_r;
    dm_req.wdata = dm_wdata_r;
    dm_req.re    = dm_re_r;
    dm_req.we    = dm_we_r;
    io_req.raddr = io_raddr_r;
    io_req.re    = io_re_r;
    io_req.waddr = io_waddr_r;
    io_req.wdata = io_wdata_r;
    io_req.we    = io_we_r;
    pm_req.addr  = pm_addr_r;
    pm_req.re    = pm_re_r;
    core_state.flags = flags_r;
    core_state.x     = x_r;
    core_state.y     = y_r;
    core_state.z     = z_r;
    core_state.sp    = sp_r;
  end

  assign sleep_req   = sleep_r;
  assign wdt_restart = wdt_r;
  assign brk_req     = brk_r;

endmodule : cbt_exec

`default_nettype wire

// ---- dv/cbt_mem.sv ----
/* data, I/O and program memory model for cbt_exec. Assumes the note's latencies. */
`timescale 1ns/100ps
`default_nettype none
module cbt_mem (
  // requests
  input  wire logic                 clk,
  input  wire cbt_pkg::cbt_dm_req_t dm_req,
  input  wire cbt_pkg::cbt_io_req_t io_req,
  input  wire cbt_pkg::cbt_pm_req_t pm_req,
  // answers
  output logic [7:0]                dm_rdata,
  output logic [7:0]                io_rdata,
  output logic [7:0]                pm_rdata
);
  import cbt_pkg::*;
  logic [7:0] dm [256];
  logic [7:0] io [64];
  logic [1:0] pv;
  logic [7:0] pa;
  // outside a read the lines flip, so a late sample cannot pass by luck
  always_ff @(posedge clk) begin
    dm_rdata <= dm_req.re ? dm[dm_req.addr[7:0]] : ~dm_rdata;
    if (dm_req.we) dm[dm_req.addr[7:0]] <= dm_req.wdata;
    if (io_req.we) io[io_req.waddr] <= io_req.wdata;
    pv <= {pv[0], pm_req.re};
    pa <= pm_req.addr[7:0];
  end
  assign io_rdata = io_req.re ? io[io_req.raddr] : ~io[io_req.raddr];
  assign pm_rdata = pv[1] ? pa ^ 8'hA5 : ~pa;
endmodule : cbt_mem
`default_nettype wire

// ---- dv/cbt_exec_chk.sv ----
/* port assertions for cbt_exec. Assumes a bind from the bench top. */
`timescale 1ns/100ps
`default_nettype none
module cbt_exec_chk (
  // watched ports
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic                 in_valid,
  input wire cbt_pkg::cbt_instr_t  in_instr,
  input wire logic                 in_ready,
  input wire cbt_pkg::cbt_io_req_t io_req,
  input wire logic [7:0]           io_rdata,
  input wire cbt_pkg::cbt_dm_req_t dm_req,
  input wire cbt_pkg::cbt_pm_req_t pm_req,
  input wire logic                 sleep_req,
  input wire logic                 wdt_restart,
  input wire cbt_pkg::cbt_state_t  core_state
);
  import cbt_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire tk = in_valid && in_ready;
  cbt_op_t o;
  assign o = in_instr.op;
  wire [7:0] f = core_state.flags;
  wire [15:0] x = core_state.x;
  AST_IOSET: assert property (
    tk && o == io_bit_set_op |=> io_req.re && io_req.raddr == $past(in_instr.io_a) && !in_ready
    ##1 io_req.we && in_ready && io_req.wdata == ($past(io_rdata) | (8'h01 << $past(in_instr.bsel, 2))))
    else $error("io bit set wrong");
  AST_IOFLAGS: assert property (
    tk && o inside {io_bit_set_op, io_bit_clear_op} |=> ##1 $stable(f) [*2])
    else $error("io bit flags");
  AST_ONECYC: assert property (
    tk && o inside {[logical_left_shift_op:transfer_flag_to_bit_op], io_in_op, io_out_op}
    |=> in_ready) else $error("one cycle op stalled");
  AST_FSET: assert property (
    tk && o == flag_set_generic_op
    |=> ##1 f == ($past(f) | (8'h01 << $past(in_instr.bsel, 2))))
    else $error("flag set wrong");
  AST_FCLR: assert property (
    tk && o == flag_clear_generic_op
    |=> ##1 f == ($past(f) & ~(8'h01 << $past(in_instr.bsel, 2))))
    else $error("flag clear wrong");
  AST_LDINC: assert property (
    tk && o == ptr_load_op && in_instr.mode == CBT_AM_INC && in_instr.ptr == CBT_PX
    |=> dm_req.re && dm_req.addr == x && !in_ready ##1 in_ready && x == $past(x) + 16'h1)
    else $error("post increment load");
  AST_STDEC: assert property (
    tk && o == ptr_store_op && in_instr.mode == CBT_AM_DEC && in_instr.ptr == CBT_PX
    |=> !dm_req.we && !in_ready
    ##1 dm_req.we && in_ready && x == $past(x) - 16'h1 && dm_req.addr == x)
    else $error("pre decrement store");
  AST_LPM: assert property (
    tk && o == program_memory_read_op |=> pm_req.re && pm_req.addr == core_state.z
    && !in_ready ##1 !in_ready ##1 in_ready) else $error("program read timing");
  AST_SLEEP: assert property (
    tk && o == sleep_op |=> sleep_req ##1 $stable(f)) else $error("sleep pulse");
  AST_WDR: assert property (
    tk && o == watchdog_restart_op |=> wdt_restart ##1 $stable(core_state))
    else $error("wdr pulse");
  cover property (tk && o == pop_op);
  cover property (tk && o == store_offset_op);
  cover property (tk && o == program_memory_read_op);
endmodule : cbt_exec_chk
`default_nettype wire

// ---- dv/cbt_exec_bench.sv ----
/* self-checking bench for cbt_exec. Assumes cbt_mem as memories. */
`timescale 1ns/100ps
`default_nettype none
module cbt_exec_bench;
  import cbt_pkg::*;
  logic clk = 0, sys_rst = 1, in_valid = 0, in_ready, sleep_req, wdt_restart, brk_req;
  cbt_instr_t in_instr = '0;
  cbt_dm_req_t dm_req;
  cbt_io_req_t io_req;
  cbt_pm_req_t pm_req;
  cbt_state_t cs;
  logic [7:0] dm_rdata, io_rdata, pm_rdata, ef;
  int n_mismatch = 0, compares = 0, cyc = 0;
  cbt_op_t sh[5] = '{arith_right_shift_op, logical_left_shift_op, rotate_right_carry_op,
                     logical_right_shift_op, rotate_left_carry_op};
  logic [15:0] sx[5] = '{16'h05C0, 16'h0580, 16'h0CC0, 16'h0060, 16'h0CC0};
  cbt_exec DUT (.clk(clk), .sys_rst(sys_rst), .in_valid(in_valid), .in_instr(in_instr),
    .in_ready(in_ready), .dm_req(dm_req), .dm_rdata(dm_rdata), .io_req(io_req),
    .io_rdata(io_rdata), .pm_req(pm_req), .pm_rdata(pm_rdata), .sleep_req(sleep_req),
    .wdt_restart(wdt_restart), .brk_req(brk_req), .core_state(cs));
  cbt_mem MEM (.clk(clk), .dm_req(dm_req), .io_req(io_req), .pm_req(pm_req),
    .dm_rdata(dm_rdata), .io_rdata(io_rdata), .pm_rdata(pm_rdata));
  initial forever #5 clk = ~clk;
  // the whole run needs about 150 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // offer one op; valid stays up so ops run back to back
  task automatic gx(cbt_op_t o, logic [4:0] r, logic [2:0] b, cbt_ptr_t p, cbt_amode_t m,
                    logic [15:0] k);
    logic ok;
    in_instr = '{o, r, r, b, k[5:0], p, m, k[5:0], k};
    in_valid = 1;
    ok = 0;
    while (!ok) begin
      #8 ok = (in_ready === 1'b1);
      @(posedge clk);
      #1;
    end
  endtask : gx
  task automatic g(cbt_op_t o, logic [4:0] r, logic [2:0] b, logic [15:0] k);
    gx(o, r, b, CBT_PX, CBT_AM_PLAIN, k);
  endtask : g
  task automatic sd(logic [4:0] r, logic [7:0] e);
    g(store_direct_op, r, 0, 16'h0010);
    g(nop_op, 0, 0, '0);
    chk("stored", {8'h00, e}, {8'h00, MEM.dm[16]});
  endtask : sd
  task automatic fl(cbt_op_t o, logic [4:0] r, logic [2:0] b, logic [7:0] e);
    g(o, r, b, '0);
    g(nop_op, 0, 0, '0);
    chk("flags", {8'h00, e}, {8'h00, cs.flags});
  endtask : fl
  task automatic end_of_test;
    $display("n_mismatch %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20) @(posedge clk);
    #1 sys_rst = 0;
    chk("sp", 16'h00FF, cs.sp);
    g(load_imm_op, 1, 0, 16'h0081);
    for (int i = 0; i < 5; i++) begin
      g(sh[i], 1, 0, '0);
      sd(1, sx[i][7:0]);
      chk("flags", {8'h00, sx[i][15:8]}, {8'h00, cs.flags});
    end
    ef = 8'h0C;
    for (int j = 0; j < 16; j++) begin
      ef = j < 8 ? ef | (8'h01 << j[2:0]) : ef & ~(8'h01 << j[2:0]);
      fl(cbt_op_t'(j < 8 ? flag_set_generic_op : flag_clear_generic_op), 0, j[2:0], ef);
    end
    fl(half_carry_set_op, 0, 0, 8'h20);
    fl(flag_set_generic_op, 0, 3, 8'h28);
    fl(overflow_clear_op, 0, 0, 8'h20);
    fl(bit_to_transfer_flag_op, 1, 6, 8'h60);
    g(load_imm_op, 2, 0, '0);
    g(transfer_flag_to_bit_op, 2, 3, '0);
    sd(2, 8'h08);
    chk("flags", 16'h0060, {8'h00, cs.flags});
    gx(ptr_set_op, 0, 0, CBT_PX, CBT_AM_PLAIN, 16'h0020);
    gx(ptr_store_op, 1, 0, CBT_PX, CBT_AM_DEC, '0);
    gx(ptr_load_op, 3, 0, CBT_PX, CBT_AM_INC, '0);
    sd(3, 8'hC0);
    chk("x", 16'h0020, cs.x);
    gx(ptr_set_op, 0, 0, CBT_PY, CBT_AM_PLAIN, 16'h0030);
    gx(ptr_store_op, 2, 0, CBT_PY, CBT_AM_INC, '0);
    gx(ptr_load_op, 4, 0, CBT_PY, CBT_AM_DEC, '0);
    gx(store_offset_op, 1, 0, CBT_PY, CBT_AM_PLAIN, 16'h0005);
    gx(load_offset_op, 5, 0, CBT_PY, CBT_AM_PLAIN, 16'h0005);
    sd(4, 8'h08);
    sd(5, 8'hC0);
    chk("y", 16'h0030, cs.y);
    gx(ptr_set_op, 0, 0, CBT_PZ, CBT_AM_PLAIN, 16'h0040);
    gx(program_memory_read_op, 6, 0, CBT_PZ, CBT_AM_INC, '0);
    sd(6, 8'hE5);
    chk("z", 16'h0041, cs.z);
    g(io_out_op, 1, 0, 16'h0005);
    g(nop_op, 0, 0, '0);
    g(io_bit_set_op, 0, 0, 16'h0005);
    g(io_bit_clear_op, 0, 7, 16'h0005);
    g(io_in_op, 7, 0, 16'h0005);
    sd(7, 8'h41);
    g(push_op, 5, 0, '0);
    g(pop_op, 8, 0, '0);
    sd(8, 8'hC0);
    chk("sp", 16'h00FF, cs.sp);
    g(swap_nibble_op, 8, 0, '0);
    sd(8, 8'h0C);
    g(load_direct_op, 9, 0, 16'h0035);
    sd(9, 8'hC0);
    g(sleep_op, 0, 0, '0);
    g(watchdog_restart_op, 0, 0, '0);
    g(break_op, 0, 0, '0);
    chk("brk", 16'h0001, {15'h0000, brk_req});
    g(nop_op, 0, 0, '0);
    chk("brk", 16'h0000, {15'h0000, brk_req});
    end_of_test();
  end
endmodule : cbt_exec_bench
bind cbt_exec cbt_exec_chk CHK (.clk(clk), .sys_rst(sys_rst), .in_valid(in_valid),
  .in_instr(in_instr), .in_ready(in_ready), .io_req(io_req), .io_rdata(io_rdata),
  .dm_req(dm_req), .pm_req(pm_req), .sleep_req(sleep_req), .wdt_restart(wdt_restart),
  .core_state(core_state));
`default_nettype wire
